// [rtl/eximg_ctrl.sv]
// Controller end: APB registers, scan trigger and forwarding of image accesses
`include "eximg_cfg.svh"
module eximg_ctrl
  import eximg_pkg::*;
(
  input logic mclk,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  eximg_if.ctrl lnk
);
  eximg_ctrl_st_t q;
  eximg_ctrl_st_t n;

  always_comb begin
    logic win;
    win = paddr[`EXI_WIN_BIT] && (paddr[11:9] == 3'h0);
    n = q;
    n.scan = 1'b0;
    n.rd = 1'b0;
    n.wr = 1'b0;
    unique case (q.st)
      EXC_IDLE: begin
        if (psel && penable) begin
          n.loc = !win;
          n.pslverr = 1'b0;
          n.prdata = `EXI_ZERO32;
          n.st = EXC_DONE;
          if (win && (paddr[`EXI_SLOT_HI:`EXI_SLOT_LO] != `EXI_EMBED_SLOT)) begin
            n.slot = paddr[`EXI_SLOT_HI:`EXI_SLOT_LO];
            n.word = paddr[`EXI_WORD_HI:`EXI_WORD_LO];
            n.wdata = pwdata[15:0];
            n.rd = !pwrite;
            n.wr = pwrite;
            n.st = EXC_WAIT;
          end else if (win) begin
            n.pslverr = 1'b1;
          end else begin
            unique case (paddr)
              `EXI_REG_CFG: n.prdata = {16'h0000, q.cfg_cur, 1'b0, q.cfg_pid, 1'b0};
              `EXI_REG_SCAN: n.prdata = {16'h0000, q.scan_cnt};
              `EXI_REG_STATUS: n.prdata = {24'h000000, lnk.present, 1'b0};
              default: n.pslverr = 1'b1;
            endcase
          end
        end
      end
      EXC_WAIT: begin
        if (lnk.ack) begin
          n.prdata = {16'h0000, lnk.rdata};
          n.st = EXC_DONE;
        end
      end
      EXC_DONE: begin
        n.st = EXC_IDLE;
        // Local writes land on the edge that completes the transfer
        if (q.loc && pwrite && !q.pslverr) begin
          if (paddr == `EXI_REG_CFG) begin
            n.cfg_pid = pwdata[`EXI_CFG_PID_LO +: 7];
            n.cfg_cur = pwdata[`EXI_CFG_CUR_LO +: 7];
          end
          if (paddr == `EXI_REG_SCAN) begin
            n.scan = 1'b1;
            n.scan_cnt = q.scan_cnt + 16'h0001;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pslverr = q.pslverr && (q.st == EXC_DONE);
  assign pready = (q.st == EXC_DONE);
  assign lnk.scan = q.scan;
  assign lnk.rd = q.rd;
  assign lnk.wr = q.wr;
  assign lnk.slot = q.slot;
  assign lnk.word = q.word;
  assign lnk.wdata = q.wdata;
  assign lnk.cfg_pid = q.cfg_pid;
  assign lnk.cfg_cur = q.cfg_cur;
endmodule : eximg_ctrl

// [rtl/eximg_cfg.svh]
// Offsets, field positions, codes and masks of the expansion image map
`ifndef EXIMG_CFG_SVH
`define EXIMG_CFG_SVH
`define EXI_FIRST_SLOT 1
`define EXI_LAST_SLOT 7
`define EXI_EMBED_SLOT 3'h0
`define EXI_WORD_W 16
`define EXI_IMG_WORDS 2
`define EXI_DATA_W 32
`define EXI_ADDR_W 12
`define EXI_REG_CFG 12'h000
`define EXI_REG_SCAN 12'h004
`define EXI_REG_STATUS 12'h008
`define EXI_WIN_BASE 12'h100
`define EXI_WIN_BIT 8
`define EXI_SLOT_HI 7
`define EXI_SLOT_LO 5
`define EXI_WORD_HI 4
`define EXI_WORD_LO 2
`define EXI_CFG_PID_LO 1
`define EXI_CFG_CUR_LO 9
`define EXI_AN_CH0 3'h0
`define EXI_AN_CH1 3'h1
`define EXI_AN_FAULT 3'h4
`define EXI_AN_FLAGS 3'h5
`define EXI_FULL_CODE 16'h7FF8
`define EXI_NORM_HI 16'h79E0
`define EXI_NORM_LO 16'h1860
`define EXI_PROP_MASK 16'hFFF8
`define EXI_PID_MASK 16'hFFFC
`define EXI_MASK6 16'h003F
`define EXI_MASK8 16'h00FF
`define EXI_MASK16 16'hFFFF
`define EXI_ZERO16 16'h0000
`define EXI_ZERO32 32'h00000000
`endif

// [rtl/eximg_pkg.sv]
// Types and mask helpers shared by both ends of the expansion image link
`include "eximg_cfg.svh"
package eximg_pkg;
  typedef enum logic [3:0] {
    EXI_NONE, EXI_IN8, EXI_IN16, EXI_IN32, EXI_OUT6, EXI_OUT8, EXI_OUT16, EXI_OUT32, EXI_AN2
  } eximg_kind_t;

  typedef enum logic [1:0] {EXC_IDLE, EXC_WAIT, EXC_DONE} eximg_cstate_t;

  typedef logic [`EXI_WORD_W-1:0] eximg_word_t;
  typedef eximg_word_t [`EXI_IMG_WORDS-1:0] eximg_pair_t;

  typedef struct packed {
    eximg_pair_t [`EXI_LAST_SLOT:`EXI_FIRST_SLOT] in_img;
    eximg_pair_t [`EXI_LAST_SLOT:`EXI_FIRST_SLOT] out_pend;
    eximg_pair_t [`EXI_LAST_SLOT:`EXI_FIRST_SLOT] out_live;
    logic [`EXI_LAST_SLOT:`EXI_FIRST_SLOT][3:0] an_flag;
    logic [`EXI_LAST_SLOT:`EXI_FIRST_SLOT] an_hw;
    eximg_word_t rdata;
    logic ack;
  } eximg_dev_st_t;

  typedef struct packed {
    eximg_cstate_t st;
    logic loc;
    logic [`EXI_DATA_W-1:0] prdata;
    logic pslverr;
    logic [`EXI_LAST_SLOT:`EXI_FIRST_SLOT] cfg_pid;
    logic [`EXI_LAST_SLOT:`EXI_FIRST_SLOT] cfg_cur;
    eximg_word_t scan_cnt;
    logic scan;
    logic rd;
    logic wr;
    logic [2:0] slot;
    logic [2:0] word;
    eximg_word_t wdata;
  } eximg_ctrl_st_t;

  function automatic eximg_word_t eximg_in_mask(eximg_kind_t k, logic w);
    eximg_word_t m;
    m = `EXI_ZERO16;
    unique case (k)
      EXI_IN8: m = w ? `EXI_ZERO16 : `EXI_MASK8;
      EXI_IN16: m = w ? `EXI_ZERO16 : `EXI_MASK16;
      EXI_IN32: m = `EXI_MASK16;
      default: m = `EXI_ZERO16;
    endcase
    return m;
  endfunction : eximg_in_mask

  function automatic eximg_word_t eximg_out_mask(eximg_kind_t k, logic w);
    eximg_word_t m;
    m = `EXI_ZERO16;
    unique case (k)
      EXI_OUT6: m = w ? `EXI_ZERO16 : `EXI_MASK6;
      EXI_OUT8: m = w ? `EXI_ZERO16 : `EXI_MASK8;
      EXI_OUT16: m = w ? `EXI_ZERO16 : `EXI_MASK16;
      EXI_OUT32: m = `EXI_MASK16;
      default: m = `EXI_ZERO16;
    endcase
    return m;
  endfunction : eximg_out_mask
endpackage : eximg_pkg

// [rtl/eximg_if.sv]
// Word link between the controller scanner and the expansion rack
interface eximg_if;
  logic scan;
  logic rd;
  logic wr;
  logic [2:0] slot;
  logic [2:0] word;
  logic [15:0] wdata;
  logic [7:1] cfg_pid;
  logic [7:1] cfg_cur;
  logic [15:0] rdata;
  logic ack;
  logic [7:1] present;
  modport dev (input scan, rd, wr, slot, word, wdata, cfg_pid, cfg_cur,
               output rdata, ack, present);
  modport ctrl (output scan, rd, wr, slot, word, wdata, cfg_pid, cfg_cur,
                input rdata, ack, present);
endinterface : eximg_if

// [rtl/eximg_dev.sv]
// Expansion rack end: slot images, discrete terminals and two-channel analog inputs
`include "eximg_cfg.svh"
module eximg_dev
  import eximg_pkg::*;
#(
  parameter eximg_kind_t [7:1] SLOT_KIND = {EXI_AN2, EXI_OUT32, EXI_IN32, EXI_OUT16,
                                            EXI_IN16, EXI_OUT8, EXI_IN8}
) (
  input logic mclk,
  input logic resetn,
  eximg_if.dev lnk,
  input logic [7:1][31:0] in_terms,
  output logic [7:1][31:0] out_terms,
  input logic [7:1][1:0][15:0] an_code,
  input logic [7:1] an_hw_err
);
  eximg_dev_st_t q;
  eximg_dev_st_t n;

  // Clamped converter code, then masked into the selected format, shifted right one bit first for PID
  function automatic eximg_word_t encode(eximg_word_t code, logic pid);
    eximg_word_t c;
    c = (code > `EXI_FULL_CODE) ? `EXI_FULL_CODE : code;
    return pid ? ({1'b0, c[15:1]} & `EXI_PID_MASK) : (c & `EXI_PROP_MASK);
  endfunction : encode

  always_comb begin
    eximg_word_t rv;
    int s;
    rv = `EXI_ZERO16;
    s = int'(lnk.slot);
    n = q;
    n.ack = 1'b0;
    for (int i = `EXI_FIRST_SLOT; i <= `EXI_LAST_SLOT; i++) begin
      // One snapshot per scan keeps every word of an image coherent
      if (lnk.scan) begin
        n.out_live[i] = q.out_pend[i];
        for (int w = 0; w < `EXI_IMG_WORDS; w++) begin
          n.in_img[i][w] = in_terms[i][w*16 +: 16] & eximg_in_mask(SLOT_KIND[i], w[0]);
        end
        if (SLOT_KIND[i] == EXI_AN2) begin
          for (int c = 0; c < 2; c++) begin
            n.in_img[i][c] = encode(an_code[i][c], lnk.cfg_pid[i]);
            // Recomputed every scan, so a flag drops once the signal is back
            n.an_flag[i][2*c+1] = an_code[i][c] > `EXI_NORM_HI;
            n.an_flag[i][2*c] = lnk.cfg_cur[i] && (an_code[i][c] < `EXI_NORM_LO);
          end
          n.an_hw[i] = an_hw_err[i];
        end
      end
    end
    // Slot 0 belongs to the controller itself and is never answered with data
    if ((lnk.rd || lnk.wr) && (lnk.slot != `EXI_EMBED_SLOT)) begin
      if (SLOT_KIND[s] inside {EXI_OUT6, EXI_OUT8, EXI_OUT16, EXI_OUT32}) begin
        if (lnk.word < 3'h2) begin
          rv = q.out_pend[s][lnk.word[0]];
          if (lnk.wr) begin
            n.out_pend[s][lnk.word[0]] = lnk.wdata
              & eximg_out_mask(SLOT_KIND[s], lnk.word[0]);
          end
        end
      end else if (SLOT_KIND[s] == EXI_AN2) begin
        unique case (lnk.word)
          `EXI_AN_CH0: rv = q.in_img[s][0];
          `EXI_AN_CH1: rv = q.in_img[s][1];
          `EXI_AN_FAULT: rv = {14'h0000,
                               |{q.an_flag[s][3:2], q.an_hw[s]},
                               |{q.an_flag[s][1:0], q.an_hw[s]}};
          `EXI_AN_FLAGS: rv = {q.an_flag[s][0], q.an_flag[s][1],
                               q.an_flag[s][2], q.an_flag[s][3], 12'h000};
          default: rv = `EXI_ZERO16;
        endcase
      end else if (lnk.word < 3'h2) begin
        rv = q.in_img[s][lnk.word[0]];
      end
    end
    if (lnk.rd || lnk.wr) begin
      n.ack = 1'b1;
      n.rdata = rv;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Slot index equals position from the left, so the port array order is the rack order
  for (genvar g = `EXI_FIRST_SLOT; g <= `EXI_LAST_SLOT; g++) begin : g_slot
    assign out_terms[g] = {q.out_live[g][1], q.out_live[g][0]};
    assign lnk.present[g] = (SLOT_KIND[g] != EXI_NONE);
  end

  assign lnk.rdata = q.rdata;
  assign lnk.ack = q.ack;
endmodule : eximg_dev

// [tb/eximg_sva.sv]
// Link checker between the controller end and the rack end
module eximg_sva (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scan,
  input wire logic rd,
  input wire logic wr,
  input wire logic [2:0] slot,
  input wire logic [2:0] word,
  input wire logic [7:1] cfg_pid,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic [7:1] present
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    rd || wr;
  endsequence
  // Analog data read of slot 7 in a given format, ending at its ack
  sequence s_an_rd(pid);
    rd && slot == 3'h7 && word <= 3'h1 && cfg_pid[7] == pid ##1 ack;
  endsequence
  AST_ACK: assert property (s_req |=> ack) else $error("no ack after request");
  AST_ACK_CAUSE: assert property (ack |-> $past(rd || wr)) else $error("stray ack");
  AST_SLOT: assert property (s_req |-> slot >= 3'h1) else $error("slot 0 on link");
  AST_SCAN: assert property (scan |=> !scan) else $error("scan not a pulse");
  AST_PRESENT: assert property (present == 7'h7F) else $error("slot missing");
  AST_PROP: assert property (s_an_rd(1'h0) |-> rdata[15] == 1'h0 && rdata[2:0] == 3'h0)
    else $error("proportional pad bits set");
  AST_PID: assert property (s_an_rd(1'h1) |-> rdata[15:14] == 2'h0 && rdata[1:0] == 2'h0)
    else $error("pid pad bits set");
  AST_IN8: assert property (rd && slot == 3'h1 ##1 ack |-> rdata[15:8] == 8'h00)
    else $error("unused input bits set");
  AST_RSVD: assert property (rd && slot == 3'h7 && word[2:1] == 2'h1 ##1 ack |-> rdata == 16'h0)
    else $error("reserved word not zero");
endmodule : eximg_sva

// [tb/tb_expansion_io_image_map.sv]
// Self-checking bench joining both ends over the link
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_expansion_io_image_map;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, err_q;
  logic [7:1][31:0] in_terms = 224'h0;
  logic [7:1][31:0] out_terms;
  logic [7:1][1:0][15:0] an_code = 224'h0;
  logic [7:1] an_hw_err = 7'h00;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  eximg_if lnk ();
  eximg_ctrl u_eximg_ctrl (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk.ctrl));
  eximg_dev u_eximg_dev (.mclk(mclk), .resetn(resetn), .lnk(lnk.dev), .in_terms(in_terms),
    .out_terms(out_terms), .an_code(an_code), .an_hw_err(an_hw_err));
  eximg_sva u_eximg_sva (.mclk(mclk), .resetn(resetn), .scan(lnk.scan), .rd(lnk.rd),
    .wr(lnk.wr), .slot(lnk.slot), .word(lnk.word), .cfg_pid(lnk.cfg_pid),
    .rdata(lnk.rdata), .ack(lnk.ack), .present(lnk.present));
  always #2.5 mclk = ~mclk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end
  // Leading edge keeps a release and the next setup out of one time step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    `CHK($sformatf("addr %h", a), e, rd_q)
  endtask : rd_chk
  function automatic logic [11:0] win(input int s, input int w);
    return 12'h100 + 12'(s * 32 + w * 4);
  endfunction : win
  // Scan pulse follows the write, terminals move one cycle later
  task automatic scan_now();
    xfer(1'h1, 12'h004, 32'h1);
    repeat (3) @(posedge mclk);
  endtask : scan_now
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'h1;
    rd_chk(12'h000, 32'h0);
    rd_chk(12'h008, 32'h000000FE);
    xfer(1'h0, win(0, 0), 32'h0);
    `CHK("slot0 err", 1'h1, err_q)
    xfer(1'h0, 12'h00C, 32'h0);
    `CHK("unmapped err", 1'h1, err_q)
    in_terms <= {64'h0, 32'hA5A55AC3, 32'h0, 32'h1234F00F, 32'h0, 32'hFFFF0EC3};
    rd_chk(win(3, 0), 32'h0);
    scan_now();
    rd_chk(win(1, 0), 32'h000000C3);
    rd_chk(win(1, 1), 32'h0);
    rd_chk(win(3, 0), 32'h0000F00F);
    rd_chk(win(5, 0), 32'h00005AC3);
    rd_chk(win(5, 1), 32'h0000A5A5);
    xfer(1'h1, win(3, 0), 32'h0000FFFF);
    rd_chk(win(3, 0), 32'h0000F00F);
    xfer(1'h1, win(2, 0), 32'h0000FFFF);
    xfer(1'h1, win(4, 0), 32'h00001234);
    xfer(1'h1, win(6, 0), 32'h0000BEEF);
    xfer(1'h1, win(6, 1), 32'h0000CAFE);
    rd_chk(win(2, 0), 32'h000000FF);
    `CHK("held", 32'h0, out_terms[2])
    scan_now();
    `CHK("out8", 32'h000000FF, out_terms[2])
    `CHK("out16", 32'h00001234, out_terms[4])
    `CHK("out32", 32'hCAFEBEEF, out_terms[6])
    rd_chk(win(6, 1), 32'h0000CAFE);
    an_code[7] <= {16'h0000, 16'h7FF8};
    scan_now();
    rd_chk(win(7, 0), 32'h00007FF8);
    rd_chk(win(7, 1), 32'h0);
    rd_chk(win(7, 2), 32'h0);
    rd_chk(win(7, 4), 32'h00000001);
    rd_chk(win(7, 5), 32'h00004000);
    xfer(1'h1, 12'h000, 32'h00008080);
    an_code[7] <= {16'h1860, 16'h79E0};
    scan_now();
    rd_chk(win(7, 0), 32'h00003CF0);
    rd_chk(win(7, 1), 32'h00000C30);
    rd_chk(win(7, 5), 32'h0);
    rd_chk(12'h000, 32'h00008080);
    an_code[7][1] <= 16'h0000;
    an_hw_err[7] <= 1'h1;
    scan_now();
    rd_chk(win(7, 4), 32'h00000003);
    rd_chk(win(7, 5), 32'h00002000);
    rd_chk(12'h004, 32'h00000005);
    end_of_test();
  end
endmodule : tb_expansion_io_image_map
